// ==== logic/ems_strobes.v ====
// External memory strobe engine: read, write and program-select pins.
// Assumes an internal master on ref_clk that holds its request until done.
`include "ems_defs.vh"
`default_nettype none

// How it works
// - Read strobe is low for the whole external read and high otherwise.
// - While read strobe is low all data pins are inputs, memory drives.
// - Read data is captured as the read strobe rises back high.
// - Address, selects and chip selects are valid while reading.
// - Write strobe goes low per write and data pins drive write data.
// - Address, selects and chip selects are valid while writing.
// - With drive control clear, strobes and program select float idle.
// - Program select goes low for each program memory access.
// - After reset chip select 0 acts as the program select.
// - Setting the control bit disables the strobe pin pull-ups.
// - Program select pin can be a general-purpose input or output.
// - In general-purpose mode clearing bit 8 drops its pull-up.
module ems_strobes #(
    parameter AW  = `EMS_ADDR_W,
    parameter DW  = `EMS_DATA_W,
    parameter CSW = `EMS_CS_W
) (
    input  wire              ref_clk,
    input  wire              rst,
    // Internal master request
    input  wire              req_valid,
    input  wire              req_write,
    input  wire              req_program,
    input  wire [AW-1:0]     req_addr,
    input  wire [DW-1:0]     req_wdata,
    input  wire [CSW-1:0]    req_chip_sel,
    output wire              req_ready,
    output reg               rsp_valid,
    output reg  [DW-1:0]     rsp_rdata,
    // Control bits
    input  wire              idle_drive_control,
    input  wire              cs0_mode,
    input  wire [`EMS_PUR_W-1:0] port_d_pullup_enable_reg,
    input  wire [7:0]        system_pullup_disable_reg,
    input  wire              gp_dir_out,
    input  wire              gp_out_value,
    output wire              gp_in_value,
    // Memory pins
    output reg  [AW-1:0]     address_lines,
    output reg               read_strobe_n,
    output wire              read_strobe_oe,
    output wire              read_strobe_pullup,
    output reg               write_strobe_n,
    output wire              write_strobe_oe,
    output wire              write_strobe_pullup,
    output wire              program_mem_select_out,
    output wire              program_mem_select_oe,
    output wire              program_mem_select_pullup,
    input  wire              program_mem_select_in,
    output reg               data_mem_select_n,
    output reg  [CSW-1:0]    chip_selects_n,
    input  wire [DW-1:0]     data_lines_in,
    output reg  [DW-1:0]     data_lines_out,
    output wire              data_lines_oe
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_END   = 2'h3;

    reg  [1:0]               state;
    reg  [1:0]               next_state;
    reg  [`EMS_CNT_W-1:0]    cnt;
    reg                      prog_sel_n;
    reg                      bus_active;
    reg                      cs0_prog;
    wire [DW-1:0]            data_sync;
    wire                     gp_sync;
    wire                     accept;
    wire                     strobe_phase;
    wire                     phase_done;

    ////////////////////////////////////////////////////////////////////////
    // Shared decoders: sequencer, counter and pin drivers use them, so one
    // definition keeps their views of the phase in step
    function is_strobe_state;
        input [1:0] st;
        begin
            is_strobe_state = (st == ST_READ) || (st == ST_WRITE);
        end
    endfunction

    function is_phase_done;
        input [`EMS_CNT_W-1:0] count;
        begin
            is_phase_done = (count == `EMS_STROBE_CYC);
        end
    endfunction

    // A pin floats when idle unless the drive control holds it
    function pin_drive;
        input drive_idle;
        input active;
        begin
            pin_drive = drive_idle | active;
        end
    endfunction

    // Accept and phase end, as seen by every process below
    assign accept       = (state == ST_IDLE) && req_valid;
    assign strobe_phase = is_strobe_state(state);
    assign phase_done   = strobe_phase && is_phase_done(cnt);

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs cross into ref_clk through three flops
    ems_pin_sync #(.W(DW)) u_data_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   (data_lines_in),
        .pin_sync (data_sync)
    );

    ems_pin_sync #(.W(1)) u_gp_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   (program_mem_select_in),
        .pin_sync (gp_sync)
    );

    assign gp_in_value = gp_sync;

    ////////////////////////////////////////////////////////////////////////
    // Mode of chip select 0 is sampled after reset release, not in reset
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs0_prog <= `EMS_CS0_PROG;
        end else begin
            cs0_prog <= cs0_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // New requests accepted only from idle, one cycle at a time
    assign req_ready = (state == ST_IDLE);

    // Transfer walk: the accept edge loads the qualifiers and drops one
    // strobe, which stays low for the counted phase; its rising edge
    // returns data and a one-cycle response, then an end cycle releases
    // the selects before the next accept
    // Strobe sequencer: one state per direction, so strobes never overlap
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_valid && req_write) begin
                    next_state = ST_WRITE;
                end else if (req_valid) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (is_phase_done(cnt)) begin
                    next_state = ST_END;
                end
            end
            ST_WRITE: begin
                if (is_phase_done(cnt)) begin
                    next_state = ST_END;
                end
            end
            ST_END: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase counter restarts on accept and runs only while a strobe is low
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= {`EMS_CNT_W{1'b0}};
        end else if (accept) begin
            cnt <= {`EMS_CNT_W{1'b0}};
        end else if (strobe_phase) begin
            cnt <= cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes fall on accept and rise together when the phase is done;
    // only one of them ever falls, so the bus never has two directions
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
        end else if (accept) begin
            read_strobe_n  <= req_write;
            write_strobe_n <= ~req_write;
        end else if (phase_done) begin
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Qualifiers load on accept, on the same edge the strobe falls, and are held
    // one cycle past the rising strobe for the memory's hold time
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            address_lines     <= {AW{1'b0}};
            chip_selects_n    <= {CSW{1'b1}};
            prog_sel_n        <= 1'b1;
            data_mem_select_n <= 1'b1;
        end else if (accept) begin
            address_lines     <= req_addr;
            chip_selects_n    <= ~req_chip_sel;
            prog_sel_n        <= ~req_program;
            data_mem_select_n <= req_program;
        end else if (state == ST_END) begin
            chip_selects_n    <= {CSW{1'b1}};
            prog_sel_n        <= 1'b1;
            data_mem_select_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data is loaded on accept and stands for the whole write
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_lines_out <= {DW{1'b0}};
        end else if (accept) begin
            data_lines_out <= req_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is taken as the read strobe rises; the strobe phase is
    // long enough for the bus to pass the three-flop synchroniser
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= {DW{1'b0}};
        end else begin
            rsp_valid <= phase_done;
            if (phase_done && (state == ST_READ)) begin
                rsp_rdata <= data_sync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus counts as active from accept until the selects are released
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_active <= 1'b0;
        end else if (accept) begin
            bus_active <= 1'b1;
        end else if (state == ST_END) begin
            bus_active <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pins drive only during writes; reads and idle leave them input
    assign data_lines_oe = (state == ST_WRITE);

    // Idle float when drive control is clear; memory sees the pull-ups
    assign read_strobe_oe  =
        pin_drive(idle_drive_control, bus_active);
    assign write_strobe_oe =
        pin_drive(idle_drive_control, bus_active);

    // Pull-ups on strobes off when the control bit is set
    assign read_strobe_pullup  =
        ~system_pullup_disable_reg[`EMS_PU_CTRL_BIT];
    assign write_strobe_pullup =
        ~system_pullup_disable_reg[`EMS_PU_CTRL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Program select pin: memory select or general-purpose port pin
    assign program_mem_select_out = cs0_prog ? prog_sel_n
                                             : gp_out_value;
    assign program_mem_select_oe  = cs0_prog
        ? pin_drive(idle_drive_control, bus_active)
        : gp_dir_out;
    assign program_mem_select_pullup = cs0_prog ? 1'b1
        : port_d_pullup_enable_reg[`EMS_PUR_PIN_BIT];

endmodule // ems_strobes

`default_nettype wire

// ==== pkg/ems_defs.vh ====
// Constants for the external memory strobe block.
// Assumes inclusion by bare name from the design files.
`ifndef EMS_DEFS_VH
`define EMS_DEFS_VH

`define EMS_ADDR_W        17
`define EMS_DATA_W        16
`define EMS_CS_W          4
`define EMS_PU_CTRL_BIT   0
`define EMS_PUR_PIN_BIT   8
`define EMS_PUR_W         16
// Last count of a strobe phase; the strobe stays low five cycles, long
// enough for read data to pass the three-flop pin synchroniser
`define EMS_STROBE_CYC    3'h4
`define EMS_CNT_W         3
// Chip select 0 mode encodings
`define EMS_CS0_PROG      1'b1
`define EMS_CS0_GP        1'b0

`endif

// ==== logic/ems_pin_sync.v ====
// Three-stage synchroniser for pin inputs that come from outside ref_clk.
// Assumes a single clock; output changes once stages two and three agree.
`default_nettype none

module ems_pin_sync #(
    parameter W = 16
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] pin_sync
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;

    ////////////////////////////////////////////////////////////////////////
    // Stage one is read only by stage two to contain metastability
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1   <= {W{1'b0}};
            stage2   <= {W{1'b0}};
            stage3   <= {W{1'b0}};
            pin_sync <= {W{1'b0}};
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // Per-bit update only where the late stages agree
            pin_sync <= (stage2 & stage3) | (pin_sync & (stage2 | stage3));
        end
    end

endmodule // ems_pin_sync

`default_nettype wire

// ==== sim/ems_mem.sv ====
// Model of the static memory on the far side of the strobe pins.
// Assumes one ref_clk; the memory's output enable is the read strobe.
`default_nettype none
module ems_mem (
    input  wire logic        ref_clk,
    input  wire logic [16:0] address_lines,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] data_lines_out,
    input  wire logic        data_lines_oe,
    output wire logic [15:0] data_lines_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [16];
    logic [15:0] last, wd;
    logic [3:0]  wa;
    logic        wprev;
    // Memory drives only while read strobe is low; released bus flips
    // every cycle so stale data never reads as good
    assign data_lines_in = data_lines_oe ? data_lines_out :
        !read_strobe_n ? mem[address_lines[3:0]] : ~last;
    // Track write data while strobe is low, commit when it rises
    always @(posedge ref_clk) begin
        last <= data_lines_in;
        if (!write_strobe_n) begin
            wa <= address_lines[3:0];
            wd <= data_lines_oe ? data_lines_out : ~data_lines_out;
        end
        if (write_strobe_n && !wprev)
            mem[wa] <= wd;
        wprev <= write_strobe_n;
    end
endmodule // ems_mem
`default_nettype wire

// ==== sim/ems_strobes_chk.sv ====
// Checker: strobe timing, select and data direction at the pins.
// Assumes binding to ems_strobes; one clock, rst async active high.
`default_nettype none
module ems_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       req_write,
    input wire logic       req_program,
    input wire logic       rsp_valid,
    input wire logic       cs0_mode,
    input wire logic       idle_drive_control,
    input wire logic [7:0] system_pullup_disable_reg,
    input wire logic       read_strobe_n,
    input wire logic       read_strobe_oe,
    input wire logic       read_strobe_pullup,
    input wire logic       write_strobe_n,
    input wire logic       program_mem_select_out,
    input wire logic       data_lines_oe,
    input wire logic       program_mem_select_oe,
    input wire logic       gp_dir_out,
    input wire logic [16:0] address_lines,
    input wire logic [3:0] chip_selects_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Accept edge, then five strobe cycles and release
    sequence s_acc; req_valid && req_ready; endsequence
    sequence s_rd; !read_strobe_n[*5] ##1 read_strobe_n; endsequence
    sequence s_wr; !write_strobe_n[*5] ##1 write_strobe_n; endsequence
    // A strobe that was already low at the previous edge
    sequence s_rd_hold; !read_strobe_n && !$past(read_strobe_n); endsequence
    sequence s_wr_hold; !write_strobe_n && !$past(write_strobe_n); endsequence
    a_read_len: assert property (s_acc ##0 !req_write |=> s_rd)
        else $error("read strobe length wrong");
    a_write_len: assert property (s_acc ##0 req_write |=> s_wr)
        else $error("write strobe length wrong");
    a_rsp_time: assert property (s_acc |-> ##6 rsp_valid)
        else $error("response not at fixed latency");
    a_prog_sel: assert property (s_acc ##0 req_program && cs0_mode
        |=> !program_mem_select_out[*5])
        else $error("program select not low for access");
    a_rd_qual: assert property (s_rd_hold |->
        $stable(address_lines) && $stable(chip_selects_n))
        else $error("read qualifiers moved under strobe");
    a_wr_qual: assert property (s_wr_hold |->
        $stable(address_lines) && $stable(chip_selects_n))
        else $error("write qualifiers moved under strobe");
    a_gp_dir: assert property (!cs0_mode && !$past(cs0_mode) |->
        program_mem_select_oe == gp_dir_out)
        else $error("general-purpose direction not followed");
    a_strobe_excl: assert property (read_strobe_n || write_strobe_n)
        else $error("both strobes low");
    a_read_in: assert property (!read_strobe_n |->
        !data_lines_oe && read_strobe_oe)
        else $error("data driven during read");
    a_write_out: assert property (!write_strobe_n |-> data_lines_oe)
        else $error("data not driven during write");
    a_idle_float: assert property (req_ready && !idle_drive_control
        && $stable(idle_drive_control) |-> !read_strobe_oe)
        else $error("read strobe driven while idle");
    a_pullup_ctl: assert property
        (read_strobe_pullup != system_pullup_disable_reg[0])
        else $error("strobe pull-up control wrong");
endmodule // ems_chk
bind ems_strobes ems_chk u_chk (.ref_clk, .rst, .req_valid, .req_ready,
    .req_write, .req_program, .rsp_valid, .cs0_mode, .idle_drive_control,
    .system_pullup_disable_reg, .read_strobe_n, .read_strobe_oe,
    .read_strobe_pullup, .write_strobe_n, .program_mem_select_out,
    .data_lines_oe, .program_mem_select_oe, .gp_dir_out, .address_lines,
    .chip_selects_n);
`default_nettype wire

// ==== sim/tb.sv ====
// Testbench for ems_strobes with a memory model on its pins.
// Assumes ems_mem and the bound checker are compiled alongside.
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst, req_valid, req_write, req_program, ps_ext;
    logic idle_drive_control, cs0_mode, gp_dir_out, gp_out_value;
    logic [16:0] req_addr;
    logic [15:0] req_wdata, port_d_pullup_enable_reg, q;
    logic [7:0]  system_pullup_disable_reg;
    logic [3:0]  req_chip_sel;
    wire req_ready, rsp_valid, gp_in_value, read_strobe_n, read_strobe_oe;
    wire read_strobe_pullup, write_strobe_n, write_strobe_oe, data_lines_oe;
    wire write_strobe_pullup, program_mem_select_out, data_mem_select_n;
    wire program_mem_select_oe, program_mem_select_pullup, ps_pin;
    wire [15:0] rsp_rdata, data_lines_in, data_lines_out;
    wire [16:0] address_lines;
    wire [3:0]  chip_selects_n;
    int mismatches, tests_run;
    // Program select pin level: our driver when the block lets go
    assign ps_pin = program_mem_select_oe ? program_mem_select_out : ps_ext;
    ems_strobes u_ems_strobes (.ref_clk, .rst, .req_valid, .req_write,
        .req_program, .req_addr, .req_wdata, .req_chip_sel, .req_ready,
        .rsp_valid, .rsp_rdata, .idle_drive_control, .cs0_mode,
        .port_d_pullup_enable_reg, .system_pullup_disable_reg, .gp_dir_out,
        .gp_out_value, .gp_in_value, .address_lines, .read_strobe_n,
        .read_strobe_oe, .read_strobe_pullup, .write_strobe_n,
        .write_strobe_oe, .write_strobe_pullup, .program_mem_select_out,
        .program_mem_select_oe, .program_mem_select_pullup,
        .program_mem_select_in(ps_pin), .data_mem_select_n,
        .chip_selects_n, .data_lines_in, .data_lines_out, .data_lines_oe);
    ems_mem u_ems_mem (.ref_clk, .address_lines, .read_strobe_n,
        .write_strobe_n, .data_lines_out, .data_lines_oe, .data_lines_in);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task finish_test;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One transfer; request held until the accept edge
    task xfer(input logic w, p, input logic [16:0] a,
              input logic [15:0] d, input logic [3:0] c);
        int n;
        {req_valid, req_write, req_program} = {1'b1, w, p};
        {req_addr, req_wdata, req_chip_sel} = {a, d, c};
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin step(1); n++; end
        if (n == 20) begin mismatches++; finish_test(); end
        step(1);
        req_valid = 1'b0;
        `CHK(w ? write_strobe_n : read_strobe_n, 1'b0)
        `CHK(p ? program_mem_select_out : data_mem_select_n, 1'b0)
        `CHK(chip_selects_n, ~c)
        `CHK(address_lines, a)
        if (w) `CHK(data_lines_out, d)
        n = 0;
        while (rsp_valid !== 1'b1 && n < 8) begin step(1); n++; end
        `CHK(n, 5)
        if (n == 8) finish_test();
        q = rsp_rdata;
    endtask
    // Back-to-back writes at the top addresses, then read back
    task t_mem;
        for (int i = 0; i < 4; i++)
            xfer(1'b1, i[0], 17'h1fffc + i, 16'h5a30 + i, 4'h1 << i);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, i[0], 17'h1fffc + i, 16'h0000, 4'h1 << i);
            `CHK(q, 16'h5a30 + i)
        end
    endtask
    // Idle drive and strobe pull-up controls
    task t_ctrl;
        idle_drive_control = 1'b1;
        step(2);
        `CHK(read_strobe_oe, 1'b1)
        `CHK(write_strobe_oe, 1'b1)
        `CHK(program_mem_select_oe, 1'b1)
        idle_drive_control = 1'b0;
        system_pullup_disable_reg = 8'h01;
        step(2);
        `CHK(read_strobe_oe, 1'b0)
        `CHK(write_strobe_oe, 1'b0)
        `CHK(write_strobe_pullup, 1'b0)
        `CHK(read_strobe_pullup, 1'b0)
        system_pullup_disable_reg = 8'h00;
        step(1);
        `CHK(write_strobe_pullup, 1'b1)
        `CHK(read_strobe_pullup, 1'b1)
    endtask
    // Program select pin as general-purpose output, then input
    task t_gpio;
        int n;
        {cs0_mode, gp_dir_out, gp_out_value} = 3'b010;
        port_d_pullup_enable_reg = 16'h0100;
        step(2);
        `CHK({program_mem_select_oe, program_mem_select_out}, 2'b10)
        `CHK(program_mem_select_pullup, 1'b1)
        port_d_pullup_enable_reg = 16'hfeff;
        {gp_dir_out, ps_ext} = 2'b01;
        step(1);
        `CHK(program_mem_select_pullup, 1'b0)
        n = 0;
        while (gp_in_value !== 1'b1 && n < 8) begin step(1); n++; end
        `CHK(gp_in_value, 1'b1)
        cs0_mode = 1'b1;
    endtask
    initial begin
        {rst, req_valid, req_write, req_program, ps_ext} = 5'h10;
        {idle_drive_control, cs0_mode, gp_dir_out, gp_out_value} = 4'h2;
        {req_addr, req_wdata, req_chip_sel, q} = '0;
        port_d_pullup_enable_reg = 16'hffff;
        system_pullup_disable_reg = 8'h00;
        step(10);
        `CHK({read_strobe_oe, program_mem_select_oe}, 2'b00)
        `CHK({read_strobe_n, data_lines_oe}, 2'b10)
        `CHK(program_mem_select_out, 1'b1)
        {cs0_mode, gp_dir_out} = 2'b10;
        rst = 1'b0;
        t_mem();
        t_ctrl();
        t_gpio();
        finish_test();
    end
endmodule // tb
`default_nettype wire
